// *** rtl/lesr_top.sv ***
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - The error word is readable by software as word index 1Dh, byte address 74h.
// - Bit 0 follows the OR of the per-station link error map and clears with it.
// - Bit 1 follows the all-stations link failure and clears with it.
// - Bit 2 follows the OR of the remote I/O error map and clears with it.
// - Bit 3 sets when an unregistered station shows up on the network.
// - If that station is at or below the final station number, bit 3 clears when it leaves.
// - If that station is above the final station number, bit 3 holds until reset.
// - Bit 4 sets on an unsupported rate code and holds until reset.
// - Bit 6 sets on a relay station outside 49..64 or in 4-point mode and holds until reset.
// - Bit 7 sets on a memory fault or on a write request outside configuration mode.
// - A bit 7 caused by a stray write request clears when the request drops.
// - A bit 7 caused by a memory fault never clears short of reset.
// - Bit 8 sets when the setting switches differ from those latched at power-on.
// - Bit 8 clears when the switches return; new settings only take hold after reset.
// - Bit 15 sets on a loopback self-test failure and holds until reset.
module lesr_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [lesr_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  input  wire logic [3:0]                wb_sel_i,
  output logic                           wb_ack_o,
  output logic [31:0]                    wb_dat_o,
  output logic                           irq_o,
  input  wire logic [lesr_pkg::MAP_W-1:0] link_err_map_i,
  input  wire logic                      link_all_fail_i,
  input  wire logic [lesr_pkg::MAP_W-1:0] rio_err_map_i,
  input  wire logic                      unreg_seen_i,
  input  wire logic [lesr_pkg::STN_W-1:0] unreg_stn_i,
  input  wire logic [lesr_pkg::STN_W-1:0] final_stn_i,
  input  wire logic                      rate_code_bad_i,
  input  wire logic                      relay_seen_i,
  input  wire logic [lesr_pkg::STN_W-1:0] relay_stn_i,
  input  wire logic                      four_point_mode_i,
  input  wire logic                      mem_fault_i,
  input  wire logic                      mem_wr_req_i,
  input  wire logic                      config_mode_i,
  input  wire logic [lesr_pkg::SW_W-1:0] op_switch_i,
  input  wire logic                      loopback_fail_i,
  output logic [15:0]                    err_flags_o
);
  import lesr_pkg::*;

  logic             started_ff;
  logic             nxt_started;
  logic [SW_W-1:0]  sw_ref_ff;
  logic [SW_W-1:0]  nxt_sw_ref;
  logic             unreg_hi_ff;
  logic             nxt_unreg_hi;
  logic             rate_ff;
  logic             nxt_rate;
  logic             relay_ff;
  logic             nxt_relay;
  logic             memf_ff;
  logic             nxt_memf;
  logic             hw_ff;
  logic             nxt_hw;
  logic [15:0]      err_ff;
  logic [15:0]      nxt_err;
  logic [15:0]      err_raw;
  logic [15:0]      err_rise;
  logic [31:0]      rd_word;
  logic             rd_pulse;
  logic             wr_pulse;
  logic [15:0]      irq_status;
  logic [15:0]      irq_mask;
  logic             irq_int;

  function automatic logic [31:0] lesr_zext(input logic [15:0] v);
    lesr_zext = {16'h0000, v};
  endfunction

  // ************************************************************
  // Latched fault state and power-on switch snapshot
  // ************************************************************
  always_comb begin
    nxt_started  = 1'b1;
    nxt_sw_ref   = started_ff ? sw_ref_ff : op_switch_i;
    nxt_unreg_hi = unreg_hi_ff | (unreg_seen_i && (unreg_stn_i > final_stn_i));
    nxt_rate     = rate_ff | rate_code_bad_i;
    nxt_relay    = relay_ff | (relay_seen_i && (four_point_mode_i ||
                   (relay_stn_i < RELAY_STN_MIN) || (relay_stn_i > RELAY_STN_MAX)));
    nxt_memf     = memf_ff | mem_fault_i;
    nxt_hw       = hw_ff | loopback_fail_i;
  end

  // ************************************************************
  // Error word assembly
  // ************************************************************
  always_comb begin
    err_raw               = 16'h0000;
    err_raw[B_LINK_SOME]  = |link_err_map_i;
    err_raw[B_LINK_ALL]   = link_all_fail_i;
    err_raw[B_RIO_ERR]    = |rio_err_map_i;
    err_raw[B_UNREG_STN]  = (unreg_seen_i && (unreg_stn_i <= final_stn_i))
                            | nxt_unreg_hi;
    err_raw[B_RATE_ERR]   = nxt_rate;
    err_raw[B_RELAY_ERR]  = nxt_relay;
    err_raw[B_MEM_ERR]    = nxt_memf | (mem_wr_req_i && !config_mode_i);
    err_raw[B_SW_CHANGED] = started_ff && (op_switch_i != sw_ref_ff);
    err_raw[B_HW_ERR]     = nxt_hw;
    nxt_err               = err_raw & ERR_USED_MASK;
    err_rise              = nxt_err & ~err_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      started_ff  <= 1'b0;
      sw_ref_ff   <= '0;
      unreg_hi_ff <= 1'b0;
      rate_ff     <= 1'b0;
      relay_ff    <= 1'b0;
      memf_ff     <= 1'b0;
      hw_ff       <= 1'b0;
      err_ff      <= ERR_RESET;
    end else if (ce_i) begin
      started_ff  <= nxt_started;
      sw_ref_ff   <= nxt_sw_ref;
      unreg_hi_ff <= nxt_unreg_hi;
      rate_ff     <= nxt_rate;
      relay_ff    <= nxt_relay;
      memf_ff     <= nxt_memf;
      hw_ff       <= nxt_hw;
      err_ff      <= nxt_err;
    end
  end

  // ************************************************************
  // Register read mux
  // ************************************************************
  always_comb begin
    unique case (wb_adr_i)
      OFS_ERR_FLAGS:  rd_word = lesr_zext(err_ff);
      OFS_IRQ_STATUS: rd_word = lesr_zext(irq_status);
      OFS_IRQ_MASK:   rd_word = lesr_zext(irq_mask);
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  lesr_wb_slave u_bus (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .cyc_i      (wb_cyc_i),
    .stb_i      (wb_stb_i),
    .we_i       (wb_we_i),
    .adr_i      (wb_adr_i),
    .rd_word_i  (rd_word),
    .ack_o      (wb_ack_o),
    .rd_pulse_o (rd_pulse),
    .wr_pulse_o (wr_pulse),
    .dat_o      (wb_dat_o)
  );

  lesr_irq u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .event_i   (err_rise),
    .clr_i     (rd_pulse && (wb_adr_i == OFS_IRQ_STATUS)),
    .mask_we_i (wr_pulse && (wb_adr_i == OFS_IRQ_MASK) && wb_sel_i[0] && wb_sel_i[1]),
    .mask_i    (wb_dat_i[15:0]),
    .status_o  (irq_status),
    .mask_o    (irq_mask),
    .irq_o     (irq_int)
  );

  assign irq_o       = irq_int;
  assign err_flags_o = err_ff;
endmodule
`default_nettype wire

// *** rtl/lesr_pkg.sv ***
package lesr_pkg;

  // ************************************************************
  // Register map (byte addresses on the 32-bit bus)
  // ************************************************************
  localparam logic [7:0]  ADDR_W          = 8'h08;
  localparam logic [7:0]  IDX_ERR_FLAGS   = 8'h1d;
  localparam logic [7:0]  OFS_ERR_FLAGS   = 8'h74;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h80;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h84;

  // ************************************************************
  // Error word fields
  // ************************************************************
  localparam int          B_LINK_SOME     = 0;
  localparam int          B_LINK_ALL      = 1;
  localparam int          B_RIO_ERR       = 2;
  localparam int          B_UNREG_STN     = 3;
  localparam int          B_RATE_ERR      = 4;
  localparam int          B_RELAY_ERR     = 6;
  localparam int          B_MEM_ERR       = 7;
  localparam int          B_SW_CHANGED    = 8;
  localparam int          B_HW_ERR        = 15;
  localparam logic [15:0] ERR_USED_MASK   = 16'h81df;
  localparam logic [15:0] ERR_RESET       = 16'h0000;

  // ************************************************************
  // Station numbering and switches
  // ************************************************************
  localparam logic [6:0]  RELAY_STN_MIN   = 7'h31;
  localparam logic [6:0]  RELAY_STN_MAX   = 7'h40;
  localparam int          SW_W            = 8;
  localparam int          STN_W           = 7;
  localparam int          MAP_W           = 64;

endpackage

// *** rtl/lesr_wb_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module lesr_wb_slave (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] rd_word_i,
  output logic             ack_o,
  output logic             rd_pulse_o,
  output logic             wr_pulse_o,
  output logic [31:0]      dat_o
);
  import lesr_pkg::*;

  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;

  // ************************************************************
  // One-cycle answer, ack dropped in the following cycle
  // ************************************************************
  always_comb begin
    nxt_ack = 1'b0;
    nxt_dat = dat_ff;
    if (cyc_i && stb_i && !ack_ff) begin
      nxt_ack = 1'b1;
      nxt_dat = we_i ? 32'h0000_0000 : rd_word_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign ack_o      = ack_ff;
  assign dat_o      = dat_ff;
  assign rd_pulse_o = ce_i && nxt_ack && !we_i;
  assign wr_pulse_o = ce_i && nxt_ack && we_i;
endmodule
`default_nettype wire

// *** rtl/lesr_irq.sv ***
`timescale 1ns/1ps
`default_nettype none
module lesr_irq (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] event_i,
  input  wire logic        clr_i,
  input  wire logic        mask_we_i,
  input  wire logic [15:0] mask_i,
  output logic [15:0]      status_o,
  output logic [15:0]      mask_o,
  output logic             irq_o
);
  import lesr_pkg::*;

  logic [15:0] sts_ff;
  logic [15:0] nxt_sts;
  logic [15:0] msk_ff;
  logic [15:0] nxt_msk;
  logic        irq_ff;
  logic        nxt_irq;

  // ************************************************************
  // Sticky status, cleared by read; a new event wins over clear
  // ************************************************************
  always_comb begin
    nxt_sts = (clr_i ? 16'h0000 : sts_ff) | event_i;
    nxt_msk = mask_we_i ? (mask_i & ERR_USED_MASK) : msk_ff;
    nxt_irq = |(nxt_sts & nxt_msk);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_ff <= 16'h0000;
      msk_ff <= 16'h0000;
      irq_ff <= 1'b0;
    end else if (ce_i) begin
      sts_ff <= nxt_sts;
      msk_ff <= nxt_msk;
      irq_ff <= nxt_irq;
    end
  end

  assign status_o = sts_ff;
  assign mask_o   = msk_ff;
  assign irq_o    = irq_ff;
endmodule
`default_nettype wire

// *** verif/lesr_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module lesr_chk
  import lesr_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire logic [MAP_W-1:0] link_err_map_i,
  input wire logic             link_all_fail_i,
  input wire logic [MAP_W-1:0] rio_err_map_i,
  input wire logic             unreg_seen_i,
  input wire logic [STN_W-1:0] unreg_stn_i,
  input wire logic [STN_W-1:0] final_stn_i,
  input wire logic             rate_code_bad_i,
  input wire logic             mem_wr_req_i,
  input wire logic             config_mode_i,
  input wire logic             loopback_fail_i,
  input wire logic [15:0]      err_flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  property p_link; ce_i |=> err_flags_o[0] == $past(|link_err_map_i); endproperty
  a_link: assert property (p_link) else $error("bit 0 wrong");
  property p_all; ce_i |=> err_flags_o[1] == $past(link_all_fail_i); endproperty
  a_all: assert property (p_all) else $error("bit 1 wrong");
  property p_rio; ce_i |=> err_flags_o[2] == $past(|rio_err_map_i); endproperty
  a_rio: assert property (p_rio) else $error("bit 2 wrong");
  property p_unused; (err_flags_o & ~ERR_USED_MASK) == 16'h0000; endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_hw; ce_i && (loopback_fail_i || err_flags_o[15]) |=> err_flags_o[15]; endproperty
  a_hw: assert property (p_hw) else $error("bit 15 not held");
  property p_rate;
    ce_i |=> err_flags_o[4] == ($past(rate_code_bad_i) || $past(err_flags_o[4]));
  endproperty
  a_rate: assert property (p_rate) else $error("bit 4 wrong");
  property p_unreg_hi;
    ce_i && unreg_seen_i && (unreg_stn_i > final_stn_i) |=> err_flags_o[3] [*4];
  endproperty
  a_unreg_hi: assert property (p_unreg_hi) else $error("bit 3 not held");
  property p_mem; ce_i && mem_wr_req_i && !config_mode_i |=> err_flags_o[7]; endproperty
  a_mem: assert property (p_mem) else $error("bit 7 not set");
endmodule
bind lesr_top lesr_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .link_err_map_i(link_err_map_i), .link_all_fail_i(link_all_fail_i),
  .rio_err_map_i(rio_err_map_i), .unreg_seen_i(unreg_seen_i), .unreg_stn_i(unreg_stn_i),
  .final_stn_i(final_stn_i), .rate_code_bad_i(rate_code_bad_i),
  .mem_wr_req_i(mem_wr_req_i), .config_mode_i(config_mode_i),
  .loopback_fail_i(loopback_fail_i), .err_flags_o(err_flags_o));
`default_nettype wire

// *** verif/lesr_stn_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lesr_stn_model
  import lesr_pkg::*;
(
  input  wire logic [STN_W-1:0] link_stn_i,
  input  wire logic [STN_W-1:0] rio_stn_i,
  input  wire logic [STN_W-1:0] new_stn_i,
  output logic [MAP_W-1:0]      link_map_o,
  output logic [MAP_W-1:0]      rio_map_o,
  output logic                  new_seen_o,
  output logic [STN_W-1:0]      new_num_o
);
  // Station number zero means that no station reports
  always_comb begin
    link_map_o = '0;
    rio_map_o = '0;
    if (link_stn_i != 7'h00) link_map_o[link_stn_i - 7'h01] = 1'b1;
    if (rio_stn_i != 7'h00) rio_map_o[rio_stn_i - 7'h01] = 1'b1;
    new_seen_o = (new_stn_i != 7'h00);
    new_num_o = new_stn_i;
  end
endmodule
`default_nettype wire

// *** verif/link_error_status_register_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_error_status_register_tb_top;
  import lesr_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic ce_i = 1'b1;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] wb_adr_i = 8'h00, op_switch_i = 8'h5a;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q[$];
  logic wb_ack_o, irq_o, unreg_seen_i, link_all_fail_i = 1'b0, rate_code_bad_i = 1'b0;
  logic relay_seen_i = 1'b0, four_point_mode_i = 1'b0, mem_fault_i = 1'b0;
  logic mem_wr_req_i = 1'b0, config_mode_i = 1'b0, loopback_fail_i = 1'b0;
  logic [6:0] unreg_stn_i, final_stn_i = 7'h0a, relay_stn_i = 7'h31;
  logic [6:0] lk = 7'h00, rio = 7'h00, nw = 7'h00;
  logic [63:0] link_err_map_i, rio_err_map_i;
  logic [15:0] err_flags_o;
  logic [6:0] rs [3] = '{7'h31, 7'h40, 7'h41};
  int bad_count = 0, checked = 0, cyc_n = 0, seed = 63554;
  always #4 clk_i = ~clk_i;
  lesr_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o),
    .link_err_map_i(link_err_map_i), .link_all_fail_i(link_all_fail_i),
    .rio_err_map_i(rio_err_map_i), .unreg_seen_i(unreg_seen_i), .unreg_stn_i(unreg_stn_i),
    .final_stn_i(final_stn_i), .rate_code_bad_i(rate_code_bad_i),
    .relay_seen_i(relay_seen_i), .relay_stn_i(relay_stn_i),
    .four_point_mode_i(four_point_mode_i), .mem_fault_i(mem_fault_i),
    .mem_wr_req_i(mem_wr_req_i), .config_mode_i(config_mode_i), .op_switch_i(op_switch_i),
    .loopback_fail_i(loopback_fail_i), .err_flags_o(err_flags_o));
  lesr_stn_model stn (.link_stn_i(lk), .rio_stn_i(rio), .new_stn_i(nw),
    .link_map_o(link_err_map_i), .rio_map_o(rio_err_map_i), .new_seen_o(unreg_seen_i),
    .new_num_o(unreg_stn_i));
  task automatic summarize;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_irq(input logic e);
    repeat (2) @(negedge clk_i);
    cmp({31'h0, e}, {31'h0, irq_o});
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    q.push_back({16'h0000, e});
    bus(a, 1'b0, 16'h0000);
  endtask
  task automatic ex(input logic [15:0] e);
    @(posedge clk_i);
    rd(OFS_ERR_FLAGS, e);
  endtask
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) cmp(q.pop_front(), wb_dat_o);
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 2000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    ex(16'h0000);
    lk <= 7'({$random(seed)} % 64 + 1);
    ex(16'h0001);
    lk <= 7'h00;
    link_all_fail_i <= 1'b1;
    ex(16'h0002);
    link_all_fail_i <= 1'b0;
    rio <= 7'({$random(seed)} % 64 + 1);
    ex(16'h0004);
    rio <= 7'h00;
    nw <= 7'h05;
    ex(16'h0008);
    nw <= 7'h00;
    ex(16'h0000);
    nw <= 7'h14;
    ex(16'h0008);
    nw <= 7'h00;
    rate_code_bad_i <= 1'b1;
    ex(16'h0018);
    rate_code_bad_i <= 1'b0;
    relay_seen_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      relay_stn_i <= rs[i];
      ex(i == 2 ? 16'h0058 : 16'h0018);
    end
    relay_seen_i <= 1'b0;
    mem_wr_req_i <= 1'b1;
    ex(16'h00d8);
    mem_wr_req_i <= 1'b0;
    ex(16'h0058);
    config_mode_i <= 1'b1;
    mem_wr_req_i <= 1'b1;
    ex(16'h0058);
    mem_fault_i <= 1'b1;
    ex(16'h00d8);
    mem_fault_i <= 1'b0;
    mem_wr_req_i <= 1'b0;
    ex(16'h00d8);
    op_switch_i <= 8'h5b;
    ex(16'h01d8);
    op_switch_i <= 8'h5a;
    loopback_fail_i <= 1'b1;
    ex(16'h80d8);
    loopback_fail_i <= 1'b0;
    bus(OFS_ERR_FLAGS, 1'b1, 16'hffff);
    ex(16'h80d8);
    rd(8'hfc, 16'h0000);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    relay_stn_i <= 7'h31;
    relay_seen_i <= 1'b1;
    four_point_mode_i <= 1'b1;
    ex(16'h0040);
    bus(OFS_IRQ_MASK, 1'b1, 16'h0001);
    rd(OFS_IRQ_MASK, 16'h0001);
    lk <= 7'({$random(seed)} % 64 + 1);
    ex(16'h0041);
    cmp_irq(1'b1);
    rd(OFS_IRQ_STATUS, 16'h0041);
    cmp_irq(1'b0);
    link_all_fail_i <= 1'b1;
    ex(16'h0043);
    cmp_irq(1'b0);
    rd(OFS_IRQ_STATUS, 16'h0002);
    ce_i <= 1'b0;
    link_all_fail_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp(32'h0000_0043, {16'h0000, err_flags_o});
    ce_i <= 1'b1;
    ex(16'h0041);
    summarize();
  end
endmodule
`default_nettype wire
